// ---- apb_host.sv ----
// Register bus host model that issues APB transfers for the bench.
`timescale 1ns/1ps
module apb_host (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata
);
    // The bus idles from time zero so no request is ever unknown.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // One transfer; ones clear flags, a byte test write wakes.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output logic to);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // The wait is bounded so that a silent slave cannot hang the run.
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        to = (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : apb_host

// ---- irq_status_upper.sv ----
// Upper interrupt status flags, mask, pending and wake logic behind APB.
`timescale 1ns/1ps
// Behaviour
// - Writing one to a status flag clears it; writing zero leaves it.
// - Software flag sets whenever its mask bit is high; write one clears it only once that mask bit is low.
// - Transmit halted flag sets once stop is requested and transmitter halted.
// - Receive halted flag sets when the receiver halts.
// - Drop counter half flag sets on 7fffffff to 80000000 step.
// - Buffer done flag sets when a marked transmit buffer is loaded.
// - Receive DMA flag sets when the programmed length has left the FIFO.
// - Timer flag sets when the down counter wraps from zero to ffff.
// - Transceiver bit is read-only, follows the transceiver, ignores writes.
// - Power flag sets on power events even with wake output disabled.
// - Writing one clears the power flag regardless of wake pin level.
// - Only a byte test register write leaves reduced power.
// - Power interrupt bypasses the deassertion interval on its own line.
// - Status overflow flag sets when the transmit status FIFO overflows.
// - Oversize flag sets when a received frame exceeds 2048 bytes.
// - Receive error flag sets on each receiver error.
// - Only masked-in flags drive interrupts; flags still record when masked.
// - Read-only pending bit is high when any enabled flag is set.
module irq_status_upper (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave port.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Event sources from the MAC and FIFO logic.
    input  wire logic        tx_stop_request,
    input  wire logic        tx_halted,
    input  wire logic        rx_halted,
    input  wire logic [31:0] drop_count,
    input  wire logic        tx_buf_loaded,
    input  wire logic        completion_notify_marker,
    input  wire logic [11:0] receive_dma_length,
    input  wire logic        rx_fifo_read,
    input  wire logic [15:0] timer_count,
    input  wire logic        transceiver_event_async,
    input  wire logic        power_event,
    input  wire logic        tx_status_overflow,
    input  wire logic        rx_byte,
    input  wire logic        rx_frame_end,
    input  wire logic        rx_error,
    // Interrupt and power outputs.
    output logic             irq_general,
    output logic             irq_power,
    output logic             irq_pending,
    output logic             wake_output_pin,
    output logic             low_power
);
    typedef struct packed {
        logic [31:0] mask;
        logic        low_power;
        logic        wake_en;
        logic        wake_pin;
        logic        irq_gen;
        logic        irq_pwr;
        logic        pending;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [31:0] drop_prev;
        logic [15:0] timer_prev;
        logic        tx_stop_prev;
        logic        rx_halt_prev;
        logic [11:0] dma_count;
        logic [11:0] rx_len;
    } top_state_t;

    top_state_t  cur_ff;
    top_state_t  nxt_ff;
    logic [31:0] flags;
    logic [31:0] flag_set;
    logic [31:0] flag_clr;
    logic [31:0] status_view;
    logic [31:0] enabled;
    logic        xcvr_level;
    logic        setup_phase;
    logic        access_done;
    logic        wr_done;
    logic        tx_stop_now;
    logic        dma_hit;
    logic        rx_len_over;
    logic [11:0] rx_len_next;
    logic [31:0] rd_word;
    logic        rd_hit;

    // The transceiver event comes from another clock domain.
    level_sync u_xcvr_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (transceiver_event_async),
        .dout    (xcvr_level)
    );

    // Sticky flags; reserved and read-only positions are never set.
    sticky_flag_bank u_flags (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (flag_set),
        .clr     (flag_clr),
        .flags   (flags)
    );

    // Bus phase decode; a transfer ends when the access phase sees pready.
    always_comb begin
        setup_phase = psel && !penable;
        access_done = psel && penable && cur_ff.pready;
        wr_done     = access_done && pwrite;
    end

    // Visible status word: sticky flags plus the live transceiver bit.
    always_comb begin
        status_view = flags & irq_upper_pkg::STATUS_W1C;
        status_view[irq_upper_pkg::BIT_XCVR] = xcvr_level;
        enabled = status_view & cur_ff.mask;
    end

    // Event detectors that turn source activity into flag sets.
    always_comb begin
        tx_stop_now = tx_stop_request && tx_halted;
        rx_len_next = cur_ff.rx_len;
        if (rx_byte && (cur_ff.rx_len <= irq_upper_pkg::OVERSIZE_MAX)) begin
            rx_len_next = cur_ff.rx_len + irq_upper_pkg::COUNT_ONE;
        end
        rx_len_over = rx_len_next > irq_upper_pkg::OVERSIZE_MAX;
        dma_hit = rx_fifo_read
                  && (receive_dma_length != irq_upper_pkg::RST_COUNT)
                  && ((cur_ff.dma_count + irq_upper_pkg::COUNT_ONE)
                      == receive_dma_length);
        flag_set = irq_upper_pkg::RST_WORD;
        flag_set[irq_upper_pkg::BIT_SW] =
            cur_ff.mask[irq_upper_pkg::BIT_SW];
        flag_set[irq_upper_pkg::BIT_TXSTOP] =
            tx_stop_now && !cur_ff.tx_stop_prev;
        flag_set[irq_upper_pkg::BIT_RXSTOP] =
            rx_halted && !cur_ff.rx_halt_prev;
        flag_set[irq_upper_pkg::BIT_DROPHALF] =
            (cur_ff.drop_prev == irq_upper_pkg::DROP_HALF_LO)
            && (drop_count == irq_upper_pkg::DROP_HALF_HI);
        flag_set[irq_upper_pkg::BIT_TXDONE] =
            tx_buf_loaded && completion_notify_marker;
        flag_set[irq_upper_pkg::BIT_RXDMA] = dma_hit;
        flag_set[irq_upper_pkg::BIT_TIMER] =
            (cur_ff.timer_prev == irq_upper_pkg::TIMER_ZERO)
            && (timer_count == irq_upper_pkg::TIMER_WRAP);
        flag_set[irq_upper_pkg::BIT_POWER] = power_event;
        flag_set[irq_upper_pkg::BIT_TXOV] = tx_status_overflow;
        flag_set[irq_upper_pkg::BIT_RXOVER] =
            rx_frame_end && rx_len_over;
        flag_set[irq_upper_pkg::BIT_RXERR] = rx_error;
    end

    // Write-one-to-clear; the power flag clears whatever the wake pin shows.
    always_comb begin
        flag_clr = irq_upper_pkg::RST_WORD;
        if (wr_done && (paddr == irq_upper_pkg::OFF_STATUS)) begin
            flag_clr = pwdata & irq_upper_pkg::STATUS_W1C;
        end
    end

    // Read mux; unmapped addresses read zero and raise pslverr.
    always_comb begin
        rd_word = irq_upper_pkg::RST_WORD;
        rd_hit  = 1'b1;
        case (paddr)
            irq_upper_pkg::OFF_IRQ_CFG: begin
                rd_word[irq_upper_pkg::BIT_PENDING] = cur_ff.pending;
            end
            irq_upper_pkg::OFF_STATUS: begin
                rd_word = status_view;
            end
            irq_upper_pkg::OFF_MASK: begin
                rd_word = cur_ff.mask;
            end
            irq_upper_pkg::OFF_BYTE_TST: begin
                rd_word = irq_upper_pkg::BYTE_TST_VAL;
            end
            irq_upper_pkg::OFF_PWR_CTRL: begin
                rd_word[irq_upper_pkg::BIT_LOWPWR]  = cur_ff.low_power;
                rd_word[irq_upper_pkg::BIT_WAKE_EN] = cur_ff.wake_en;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Next state of the block.
    always_comb begin
        nxt_ff = cur_ff;

        // The slave answers in the first access cycle; data is set up early.
        nxt_ff.pready  = setup_phase;
        nxt_ff.pslverr = setup_phase && !rd_hit;
        if (setup_phase) begin
            nxt_ff.prdata = pwrite ? irq_upper_pkg::RST_WORD : rd_word;
        end

        // Mask register; reserved positions stay zero.
        if (wr_done && (paddr == irq_upper_pkg::OFF_MASK)) begin
            nxt_ff.mask = pwdata & irq_upper_pkg::MASK_RW;
        end

        // Power control: software enters reduced power and sets the wake enable.
        if (wr_done && (paddr == irq_upper_pkg::OFF_PWR_CTRL)) begin
            nxt_ff.wake_en = pwdata[irq_upper_pkg::BIT_WAKE_EN];
            if (pwdata[irq_upper_pkg::BIT_LOWPWR]) begin
                nxt_ff.low_power = 1'b1;
            end
        end
        // Wake-up needs a host write to the byte test register, nothing else.
        if (wr_done && (paddr == irq_upper_pkg::OFF_BYTE_TST)) begin
            nxt_ff.low_power = 1'b0;
        end

        // Wake pin follows the power flag only while enabled; it never wakes us.
        nxt_ff.wake_pin = cur_ff.wake_en
                          && status_view[irq_upper_pkg::BIT_POWER];

        // The power source has its own line so the interval timer cannot hold it.
        nxt_ff.irq_pwr = enabled[irq_upper_pkg::BIT_POWER];
        nxt_ff.irq_gen = |(enabled & ~(32'h1 << irq_upper_pkg::BIT_POWER));
        nxt_ff.pending = |enabled;

        // Histories for edge detection of levels and counters.
        nxt_ff.drop_prev    = drop_count;
        nxt_ff.timer_prev   = timer_count;
        nxt_ff.tx_stop_prev = tx_stop_now;
        nxt_ff.rx_halt_prev = rx_halted;

        // Receive DMA progress restarts after each hit.
        if (dma_hit) begin
            nxt_ff.dma_count = irq_upper_pkg::RST_COUNT;
        end else if (rx_fifo_read) begin
            nxt_ff.dma_count = cur_ff.dma_count + irq_upper_pkg::COUNT_ONE;
        end

        // Frame length saturates just past the limit, so it cannot wrap back.
        if (rx_frame_end) begin
            nxt_ff.rx_len = irq_upper_pkg::RST_COUNT;
        end else begin
            nxt_ff.rx_len = rx_len_next;
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff <= '{
                mask:         irq_upper_pkg::RST_WORD,
                low_power:    1'b0,
                wake_en:      1'b0,
                wake_pin:     1'b0,
                irq_gen:      1'b0,
                irq_pwr:      1'b0,
                pending:      1'b0,
                prdata:       irq_upper_pkg::RST_WORD,
                pready:       1'b0,
                pslverr:      1'b0,
                drop_prev:    irq_upper_pkg::RST_WORD,
                timer_prev:   irq_upper_pkg::RST_TIMER,
                tx_stop_prev: 1'b0,
                rx_halt_prev: 1'b0,
                dma_count:    irq_upper_pkg::RST_COUNT,
                rx_len:       irq_upper_pkg::RST_COUNT
            };
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // Outputs come straight from the state register.
    assign prdata          = cur_ff.prdata;
    assign pready          = cur_ff.pready;
    assign pslverr         = cur_ff.pslverr;
    assign irq_general     = cur_ff.irq_gen;
    assign irq_power       = cur_ff.irq_pwr;
    assign irq_pending     = cur_ff.pending;
    assign wake_output_pin = cur_ff.wake_pin;
    assign low_power       = cur_ff.low_power;
endmodule : irq_status_upper

// ---- irq_status_upper_bench.sv ----
// Self-checking bench for the upper interrupt status block.
`timescale 1ns/1ps
module irq_status_upper_bench;
    logic        pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r, seed = 32'h9f01933f;
    logic        tx_stop_request = 1'b0, tx_halted = 1'b0, rx_halted = 1'b0, tx_buf_loaded = 1'b0;
    logic        completion_notify_marker = 1'b0, rx_fifo_read = 1'b0, transceiver_event_async = 1'b0;
    logic        power_event = 1'b0, tx_status_overflow = 1'b0, rx_byte = 1'b0, rx_frame_end = 1'b0;
    logic        rx_error = 1'b0, e, irq_general, irq_power, irq_pending, wake_output_pin, low_power;
    logic [31:0] drop_count = 32'h0;
    logic [11:0] receive_dma_length = 12'h0;
    logic [15:0] timer_count = 16'hffff;
    int          checks = 0, mismatches = 0, len;

    // The clock toggles every half period of 2.5 ns.
    always #2.5 pclk = ~pclk;

    irq_status_upper u_irq_status_upper (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_stop_request(tx_stop_request), .tx_halted(tx_halted), .rx_halted(rx_halted),
        .drop_count(drop_count), .tx_buf_loaded(tx_buf_loaded), .completion_notify_marker(completion_notify_marker),
        .receive_dma_length(receive_dma_length), .rx_fifo_read(rx_fifo_read), .timer_count(timer_count),
        .transceiver_event_async(transceiver_event_async), .power_event(power_event),
        .tx_status_overflow(tx_status_overflow), .rx_byte(rx_byte), .rx_frame_end(rx_frame_end),
        .rx_error(rx_error), .irq_general(irq_general), .irq_power(irq_power), .irq_pending(irq_pending),
        .wake_output_pin(wake_output_pin), .low_power(low_power));
    apb_host u_apb_host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Status word expected after each stimulus kind; the last two are near misses.
    function automatic logic [31:0] ev(input int k);
        int unsigned pos[10] = '{25, 24, 23, 21, 20, 19, 17, 16, 15, 14};
        return (k < 10) ? (32'h1 << pos[k]) : 32'h0;
    endfunction : ev

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // A hung transfer counts as a mismatch and closes the run.
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic to;
        u_apb_host.xfer(w, a, d, r, e, to);
        if (to) begin
            mismatches++;
            $display("MISMATCH %0t bus timeout", $time);
            end_of_test();
        end
    endtask : acc
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        cmp(r, exp);
    endtask : rchk
    // Pulses and levels are launched on one edge and dropped on the next sampled edge.
    task automatic stim(input int k);
        @(posedge pclk);
        case (k)
            0: begin
                tx_stop_request <= 1'b1;
                tx_halted <= 1'b1;
            end
            1: rx_halted <= 1'b1;
            2: begin
                drop_count <= irq_upper_pkg::DROP_HALF_LO;
                @(posedge pclk);
                drop_count <= irq_upper_pkg::DROP_HALF_HI;
            end
            3: begin
                tx_buf_loaded <= 1'b1;
                completion_notify_marker <= 1'b1;
            end
            4: repeat (len) begin
                rx_fifo_read <= 1'b1;
                @(posedge pclk);
                rx_fifo_read <= 1'b0;
                @(posedge pclk);
            end
            5: begin
                timer_count <= irq_upper_pkg::TIMER_ZERO;
                @(posedge pclk);
                timer_count <= irq_upper_pkg::TIMER_WRAP;
            end
            6: power_event <= 1'b1;
            7: tx_status_overflow <= 1'b1;
            8, 10: begin
                rx_byte <= 1'b1;
                repeat (k == 8 ? 2049 : 2048) @(posedge pclk);
                rx_byte <= 1'b0;
                rx_frame_end <= 1'b1;
            end
            9: rx_error <= 1'b1;
            default: tx_buf_loaded <= 1'b1;
        endcase
        @(posedge pclk);
        {tx_stop_request, tx_halted, rx_halted, tx_buf_loaded, completion_notify_marker} <= 5'h00;
        {power_event, tx_status_overflow, rx_frame_end, rx_error} <= 4'h0;
    endtask : stim

    // Main sequence: reset values, each stimulus kind while masked, then the interrupt lines.
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        len = 1 + int'(seed[2:0]);
        receive_dma_length <= 12'(len);
        rchk(irq_upper_pkg::OFF_STATUS, 32'h0);
        rchk(irq_upper_pkg::OFF_MASK, 32'h0);
        rchk(irq_upper_pkg::OFF_BYTE_TST, irq_upper_pkg::BYTE_TST_VAL);
        acc(1'b0, 8'h5a, 32'h0);
        cmp({31'h0, e}, 32'h1);
        acc(1'b1, irq_upper_pkg::OFF_PWR_CTRL, 32'h1);
        for (int k = 0; k < 12; k++) begin
            stim(k);
            repeat (2) @(posedge pclk);
            cmp({31'h0, irq_pending}, 32'h0);
            rchk(irq_upper_pkg::OFF_STATUS, ev(k));
            seed = lfsr(seed);
            acc(1'b1, irq_upper_pkg::OFF_STATUS, seed & ~ev(k));
            rchk(irq_upper_pkg::OFF_STATUS, ev(k));
            acc(1'b1, irq_upper_pkg::OFF_STATUS, ev(k));
            rchk(irq_upper_pkg::OFF_STATUS, 32'h0);
        end
        cmp({31'h0, low_power}, 32'h1);
        acc(1'b1, irq_upper_pkg::OFF_MASK, 32'hffff_ffff);
        rchk(irq_upper_pkg::OFF_MASK, irq_upper_pkg::MASK_RW);
        acc(1'b1, irq_upper_pkg::OFF_STATUS, 32'hffff_ffff);
        rchk(irq_upper_pkg::OFF_STATUS, 32'h8000_0000);
        acc(1'b1, irq_upper_pkg::OFF_MASK, irq_upper_pkg::MASK_RW & 32'h7fff_ffff);
        acc(1'b1, irq_upper_pkg::OFF_STATUS, 32'h8000_0000);
        rchk(irq_upper_pkg::OFF_STATUS, 32'h0);
        stim(9);
        repeat (2) @(posedge pclk);
        cmp({29'h0, irq_general, irq_pending, irq_power}, 32'h6);
        // The clear lands on the same edge as a new error, so the flag must survive.
        fork
            acc(1'b1, irq_upper_pkg::OFF_STATUS, 32'h0000_4000);
            begin
                repeat (2) @(posedge pclk);
                rx_error <= 1'b1;
                @(posedge pclk);
                rx_error <= 1'b0;
            end
        join
        rchk(irq_upper_pkg::OFF_STATUS, 32'h0000_4000);
        acc(1'b1, irq_upper_pkg::OFF_STATUS, 32'h0000_4000);
        stim(6);
        repeat (2) @(posedge pclk);
        cmp({28'h0, irq_general, irq_power, wake_output_pin, low_power}, 32'h5);
        acc(1'b1, irq_upper_pkg::OFF_PWR_CTRL, 32'h2);
        repeat (2) @(posedge pclk);
        cmp({31'h0, wake_output_pin}, 32'h1);
        acc(1'b1, irq_upper_pkg::OFF_STATUS, 32'h0002_0000);
        repeat (2) @(posedge pclk);
        cmp({30'h0, irq_power, wake_output_pin}, 32'h0);
        acc(1'b1, irq_upper_pkg::OFF_BYTE_TST, seed);
        @(posedge pclk);
        cmp({31'h0, low_power}, 32'h0);
        transceiver_event_async <= 1'b1;
        repeat (6) @(posedge pclk);
        acc(1'b1, irq_upper_pkg::OFF_STATUS, 32'h0004_0000);
        rchk(irq_upper_pkg::OFF_STATUS, 32'h0004_0000);
        cmp({31'h0, irq_pending}, 32'h1);
        rchk(irq_upper_pkg::OFF_IRQ_CFG, 32'h0000_1000);
        transceiver_event_async <= 1'b0;
        repeat (6) @(posedge pclk);
        rchk(irq_upper_pkg::OFF_STATUS, 32'h0);
        end_of_test();
    end
endmodule : irq_status_upper_bench

// ---- irq_status_upper_chk.sv ----
// Port-level assertions for the upper interrupt status block.
`timescale 1ns/1ps
module irq_status_upper_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        power_event,
    input wire logic        irq_general,
    input wire logic        irq_power,
    input wire logic        irq_pending,
    input wire logic        wake_output_pin,
    input wire logic        low_power
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A write counts only at the edge where the access phase completes.
    wire logic wr_done = psel && penable && pready && pwrite;
    wire logic setup = psel && !penable;

    property p_answer; setup |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no ready after setup");
    property p_unmapped; setup && paddr[1:0] != 2'b00 |=> pslverr && prdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("bad unmapped answer");
    property p_reserved;
        setup && !pwrite && paddr == irq_upper_pkg::OFF_STATUS |=> prdata[30:26] == 5'h00 && !prdata[22];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved status bits set");
    property p_soft; wr_done && paddr == irq_upper_pkg::OFF_MASK && pwdata[31] |-> ##[2:4] irq_general; endproperty
    a_soft: assert property (p_soft) else $error("software request not raised");
    property p_pend; irq_general || irq_power |-> irq_pending; endproperty
    a_pend: assert property (p_pend) else $error("pending low with active line");
    property p_lp_hold; low_power && !(wr_done && paddr == irq_upper_pkg::OFF_BYTE_TST) |=> low_power; endproperty
    a_lp_hold: assert property (p_lp_hold) else $error("left low power without wake write");
    property p_lp_exit; wr_done && paddr == irq_upper_pkg::OFF_BYTE_TST |=> !low_power; endproperty
    a_lp_exit: assert property (p_lp_exit) else $error("wake write ignored");
    property p_lp_enter; wr_done && paddr == irq_upper_pkg::OFF_PWR_CTRL && pwdata[0] |=> low_power; endproperty
    a_lp_enter: assert property (p_lp_enter) else $error("low power not entered");
    property p_pw_clr;
        (wr_done && paddr == irq_upper_pkg::OFF_STATUS && pwdata[17] && !power_event) ##1 !power_event
            |=> !irq_power && !wake_output_pin;
    endproperty
    a_pw_clr: assert property (p_pw_clr) else $error("power flag not cleared");
    // Main scenarios that the bench is expected to reach.
    c_wake: cover property (wr_done && paddr == irq_upper_pkg::OFF_BYTE_TST);
    c_power: cover property (irq_power && wake_output_pin);
    c_err: cover property (pready && pslverr);
endmodule : irq_status_upper_chk

bind irq_status_upper irq_status_upper_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .power_event(power_event),
    .irq_general(irq_general), .irq_power(irq_power), .irq_pending(irq_pending),
    .wake_output_pin(wake_output_pin), .low_power(low_power));

// ---- irq_upper_pkg.sv ----
// Constants shared by the upper interrupt status block and its helpers.
package irq_upper_pkg;
    // Register bus geometry.
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 32;
    // Register byte offsets.
    localparam logic [7:0]  OFF_IRQ_CFG  = 8'h54;
    localparam logic [7:0]  OFF_STATUS   = 8'h58;
    localparam logic [7:0]  OFF_MASK     = 8'h5c;
    localparam logic [7:0]  OFF_BYTE_TST = 8'h64;
    localparam logic [7:0]  OFF_PWR_CTRL = 8'hc0;
    // Flag positions inside the status and mask words, plus the pending and power control bits.
    localparam int unsigned BIT_SW       = 31;
    localparam int unsigned BIT_TXSTOP   = 25;
    localparam int unsigned BIT_RXSTOP   = 24;
    localparam int unsigned BIT_DROPHALF = 23;
    localparam int unsigned BIT_TXDONE   = 21;
    localparam int unsigned BIT_RXDMA    = 20;
    localparam int unsigned BIT_TIMER    = 19;
    localparam int unsigned BIT_XCVR     = 18;
    localparam int unsigned BIT_POWER    = 17;
    localparam int unsigned BIT_TXOV     = 16;
    localparam int unsigned BIT_RXOVER   = 15;
    localparam int unsigned BIT_RXERR    = 14;
    localparam int unsigned BIT_PENDING  = 12;
    localparam int unsigned BIT_LOWPWR   = 0;
    localparam int unsigned BIT_WAKE_EN  = 1;
    // Writable mask bits and write-one-to-clear status bits.
    localparam logic [31:0] MASK_RW      = 32'h83bf_c000;
    localparam logic [31:0] STATUS_W1C   = 32'h83bb_c000;
    // Values after reset.
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
    localparam logic [15:0] RST_TIMER    = 16'hffff;
    localparam logic [11:0] RST_COUNT    = 12'h000;
    // Fixed read value of the byte order test register.
    localparam logic [31:0] BYTE_TST_VAL = 32'h8765_4321;
    // Event thresholds and the count step.
    localparam logic [31:0] DROP_HALF_LO = 32'h7fff_ffff;
    localparam logic [31:0] DROP_HALF_HI = 32'h8000_0000;
    localparam logic [15:0] TIMER_ZERO   = 16'h0000;
    localparam logic [15:0] TIMER_WRAP   = 16'hffff;
    localparam logic [11:0] OVERSIZE_MAX = 12'h800;
    localparam logic [11:0] COUNT_ONE    = 12'h001;
endpackage : irq_upper_pkg

// ---- level_sync.sv ----
// Three-stage synchroniser that passes a level once two stages agree.
`timescale 1ns/1ps
module level_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sync_state_t;

    sync_state_t cur_ff;
    sync_state_t nxt_ff;

    // The first stage feeds only the second, so metastability stays contained.
    always_comb begin
        nxt_ff    = cur_ff;
        nxt_ff.s1 = din;
        nxt_ff.s2 = cur_ff.s1;
        nxt_ff.s3 = cur_ff.s2;
        if (cur_ff.s2 == cur_ff.s3) begin
            nxt_ff.level = cur_ff.s3;
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign dout = cur_ff.level;
endmodule : level_sync

// ---- sticky_flag_bank.sv ----
// Bank of sticky status flags, set by hardware and cleared by software.
`timescale 1ns/1ps
module sticky_flag_bank (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [31:0] set,
    input  wire logic [31:0] clr,
    output logic      [31:0] flags
);
    typedef struct packed {
        logic [31:0] q;
    } bank_state_t;

    bank_state_t cur_ff;
    bank_state_t nxt_ff;
    logic [31:0] nxt_bits;

    // A set in the same cycle as a clear wins, so no event is lost.
    genvar i;
    generate
        for (i = 0; i < 32; i++) begin : g_flag
            assign nxt_bits[i] = set[i] | (cur_ff.q[i] & ~clr[i]);
        end
    endgenerate

    // Next state copy.
    always_comb begin
        nxt_ff   = cur_ff;
        nxt_ff.q = nxt_bits;
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff <= '{q: irq_upper_pkg::RST_WORD};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign flags = cur_ff.q;
endmodule : sticky_flag_bank
